// ===== dv/flrf_checker.sv
// port checker for the fault record formatter
// assumes one clock and an async active-low reset
`timescale 1ns/10ps
module flrf_checker (
	input wire       clk,
	input wire       rst_n,
	input wire       step_vld,
	input wire [4:0] step_num,
	input wire       busy_r,
	input wire       commit_r,
	input wire       log_valid_r,
	input wire [7:0] blk_len_r,
	input wire       rd_vld_r
);
default clocking @(posedge clk); endclocking
default disable iff (!rst_n);
chk_commit_after_end: assert property (
	busy_r && step_vld && step_num == 5'h19 |-> ##25 commit_r) else $error("no commit");
chk_commit_state: assert property (
	commit_r |=> log_valid_r && !busy_r) else $error("bad state after commit");
chk_len_legal: assert property (
	blk_len_r == 8'h00 || blk_len_r == 8'h93) else $error("bad block length");
chk_no_log_no_byte: assert property (
	!log_valid_r |=> !rd_vld_r) else $error("byte without log");
chk_len_needs_log: assert property (
	blk_len_r == 8'h93 |-> log_valid_r) else $error("length without log");
chk_busy_ends_commit: assert property (
	$fell(busy_r) |-> commit_r) else $error("busy dropped without commit");
endmodule
bind flrf_top flrf_checker chk (.clk, .rst_n, .step_vld, .step_num, .busy_r, .commit_r,
	.log_valid_r, .blk_len_r, .rd_vld_r);

// ===== dv/flrf_host.sv
// host model: starts a block read, requests n bytes back to back, keeps them
// assumes each byte request is answered two cycles later
`timescale 1ns/10ps
module flrf_host (
	input  wire       clk,
	input  wire [7:0] rd_byte_r,
	input  wire       rd_vld_r,
	output reg        fault_record_block_read,
	output reg        rd_next
);
reg [7:0] got [0:63];
int cnt = 0;
initial begin
	fault_record_block_read = 0;
	rd_next = 0;
end
always @(posedge clk) if (rd_vld_r) begin
	got[cnt] <= rd_byte_r;
	cnt <= cnt + 1;
end
task fetch(input int n);
	begin
		@(posedge clk) fault_record_block_read <= 1;
		cnt = 0;
		@(posedge clk) fault_record_block_read <= 0;
		rd_next <= 1;
		repeat (n) @(posedge clk);
		rd_next <= 0;
	end
endtask
endmodule

// ===== dv/test_fault_log_record_formatter.sv
// bench: empty read, then a fault mid pass and a read of the record
// assumes flrf_host plays the reading host
`timescale 1ns/10ps
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin err_count++; \
	$display("BAD %s exp %h got %h", n, e, s); end end
module test_fault_log_record_formatter;
// record bytes 23..45 after step 25, first byte in the top bits
localparam [183:0] EXP = 184'h01190219031904190519061907190819B9D909190A19F9;
reg clk = 0, rst_n = 0, fault_evt = 0, step_vld = 0;
reg [4:0] step_num = 0;
reg [15:0] w [1:10] = '{default: 0};
reg [7:0] b [0:2] = '{default: 0};
wire [7:0] blk_len_r, rd_byte_r;
wire rd_vld_r, log_valid_r, busy_r, commit_r, fault_record_block_read, rd_next;
int err_count = 0, checks = 0;
flrf_top dut (.clk, .rst_n, .fault_evt, .step_vld, .step_num, .temp1_val(w[1]), .temp2_val(w[2]),
	.vout0_val(w[3]), .vout1_val(w[4]), .iout0_val(w[5]), .iout1_val(w[6]), .vin_val(w[7]),
	.iin_val(w[8]), .sword0_val(w[9]), .sword1_val(w[10]), .svout0_val(b[0]), .svout1_val(b[1]),
	.smfr0_val(b[2]), .fault_record_block_read, .rd_next, .blk_len_r, .rd_byte_r, .rd_vld_r,
	.log_valid_r, .busy_r, .commit_r);
flrf_host host (.clk, .rd_byte_r, .rd_vld_r, .fault_record_block_read, .rd_next);
initial forever #50 clk = ~clk;
task conclude;
	begin
		$display("errors %0d checks %0d", err_count, checks);
		if (err_count == 0 && checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	end
endtask
task t_empty;
	begin
		host.fetch(2);
		repeat (4) @(posedge clk);
		`CHK("len", 8'h00, blk_len_r)
		`CHK("bytes", 0, host.cnt)
	end
endtask
task t_capture;
	int k, s, n;
	begin
		@(posedge clk) fault_evt <= 1;
		// fault lands at step 15; only step 25 values may survive
		for (s = 15; s < 26; s++) @(posedge clk) begin
			fault_evt <= 0;
			step_vld <= 1;
			step_num <= s[4:0];
			for (k = 1; k < 11; k++) w[k] <= {k[7:0], 3'h0, s[4:0]};
			for (k = 0; k < 3; k++) b[k] <= 8'(160 + 32 * k + s);
		end
		@(posedge clk) step_vld <= 0;
		`CHK("busy", 1'b1, busy_r)
		for (n = 0; !commit_r && n < 40; n++) @(posedge clk);
		`CHK("commit", 1'b1, commit_r)
		if (n == 40) conclude;
		@(posedge clk);
		`CHK("valid", 1'b1, log_valid_r)
		`CHK("idle", 1'b0, busy_r)
		host.fetch(46);
		for (n = 0; host.cnt < 46 && n < 9; n++) @(posedge clk);
		`CHK("len", 8'h93, blk_len_r)
		if (n == 9) begin
			err_count++;
			conclude;
		end
		for (k = 23; k < 46; k++) `CHK("byte", EXP[8 * (45 - k) +: 8], host.got[k])
	end
endtask
initial begin
	repeat (12) @(posedge clk);
	rst_n <= 1;
	t_empty;
	t_capture;
	conclude;
end
endmodule

// ===== hdl/flrf_mem.v
// record memory for the fault log: one write port, one registered read port
// assumes single clock; contents are undefined until written
`timescale 1ns/10ps
`include "flrf_regs.vh"
module flrf_mem (
	input  wire       clk,
	input  wire       wr_en,
	input  wire [7:0] wr_addr,
	input  wire [7:0] wr_data,
	input  wire [7:0] rd_addr,
	output reg  [7:0] rd_data
);
	reg [7:0] mem [0:`FLRF_REC_LEN - 8'h01];

	always @(posedge clk) begin
		if (wr_en)
			mem[wr_addr] <= wr_data;
		rd_data <= mem[rd_addr];
	end
endmodule

// ===== hdl/flrf_regs.vh
// constants for the fault record formatter: byte positions, lengths, step counts
// assumes a 10 MHz system clock and 8-bit record bytes
`ifndef FLRF_REGS_VH
`define FLRF_REGS_VH
`define FLRF_REC_LEN        8'h93
`define FLRF_NO_LOG_LEN     8'h00
`define FLRF_IDX_TEMP1_HI   8'h17
`define FLRF_IDX_TEMP1_LO   8'h18
`define FLRF_IDX_TEMP2_HI   8'h19
`define FLRF_IDX_TEMP2_LO   8'h1A
`define FLRF_IDX_PAGE_BASE  8'h1B
`define FLRF_IDX_MFR0       8'h2D
`define FLRF_PAGE_LEN       8'h13
`define FLRF_NUM_PAGES      3'h6
`define FLRF_LAST_STEP      5'h19
`define FLRF_ADDR_W         8
`endif

// ===== hdl/flrf_top.v
// fault record formatter: captures temperatures and one event page at the first step 25 after a fault,
// commits the record after the last step, and streams it for a block read.
// assumes adc step results arrive as one-cycle pulses from same-clock logic.
`timescale 1ns/10ps
`include "flrf_regs.vh"
module flrf_top (
	input  wire        clk,
	input  wire        rst_n,
	input  wire        fault_evt,
	input  wire        step_vld,
	input  wire [4:0]  step_num,
	input  wire [15:0] temp1_val,
	input  wire [15:0] temp2_val,
	input  wire [15:0] vout0_val,
	input  wire [15:0] vout1_val,
	input  wire [15:0] iout0_val,
	input  wire [15:0] iout1_val,
	input  wire [15:0] vin_val,
	input  wire [15:0] iin_val,
	input  wire [7:0]  svout0_val,
	input  wire [7:0]  svout1_val,
	input  wire [15:0] sword0_val,
	input  wire [15:0] sword1_val,
	input  wire [7:0]  smfr0_val,
	input  wire        fault_record_block_read,
	input  wire        rd_next,
	output reg  [7:0]  blk_len_r,
	output reg  [7:0]  rd_byte_r,
	output reg         rd_vld_r,
	output reg         log_valid_r,
	output reg         busy_r,
	output reg         commit_r
);
	localparam S_IDLE = 4'b0001;
	localparam S_PASS = 4'b0010;
	localparam S_WRT  = 4'b0100;
	localparam S_DONE = 4'b1000;


	localparam PAGE_TOP = 8 * `FLRF_PAGE_LEN - 1;

	reg  [3:0]        st_r;
	reg  [7:0]        widx_r;
	reg  [7:0]        ridx_r;
	reg  [7:0]        wr_data;
	reg  [7:0]        pidx;
	reg  [15:0]       t1_r;
	reg  [15:0]       t2_r;
	reg               rd_pend_r;

	wire [7:0]        mem_q;
	wire              wr_en;
	wire              take_step;
	wire              take_byte;
	wire [PAGE_TOP:0] page_img;
	wire [PAGE_TOP:0] page_q;

	genvar            g;

	assign wr_en     = (st_r == S_WRT);
	assign take_step = (st_r == S_PASS) && step_vld;
	// a new block read wins over a byte request in the same cycle
	assign take_byte = rd_next && log_valid_r && (ridx_r < `FLRF_REC_LEN) &&
		!fault_record_block_read;

	// event page image, record order, high byte first
	assign page_img = {
		vout0_val,
		vout1_val,
		iout0_val,
		iout1_val,
		vin_val,
		iin_val,
		svout0_val,
		svout1_val,
		sword0_val,
		sword1_val,
		smfr0_val
	};

	// every page byte is retaken on each step, so the last step of the pass wins
	// one register per page byte keeps the load free of a wide multiplexer
	generate
		for (g = 0; g < `FLRF_PAGE_LEN; g = g + 1) begin : g_page
			reg [7:0] byte_r;
			always @(posedge clk or negedge rst_n) begin
				if (!rst_n)
					byte_r <= 8'h00;
				else if (take_step)
					byte_r <= page_img[PAGE_TOP - 8 * g -: 8];
			end
			assign page_q[PAGE_TOP - 8 * g -: 8] = byte_r;
		end
	endgenerate

	always @* begin
		wr_data = 8'h00;
		pidx    = widx_r - `FLRF_IDX_PAGE_BASE;
		// widx_r walks record addresses; the page image counts from its first byte
		case (widx_r)
			`FLRF_IDX_TEMP1_HI: wr_data = t1_r[15:8];
			`FLRF_IDX_TEMP1_LO: wr_data = t1_r[7:0];
			`FLRF_IDX_TEMP2_HI: wr_data = t2_r[15:8];
			`FLRF_IDX_TEMP2_LO: wr_data = t2_r[7:0];
			default: begin
				if (widx_r >= `FLRF_IDX_PAGE_BASE &&
					widx_r <= `FLRF_IDX_MFR0)
					wr_data = page_q[PAGE_TOP - 8 * pidx -: 8];
			end
		endcase
	end

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_r        <= S_IDLE;
			widx_r      <= 8'h00;
			t1_r        <= 16'h0000;
			t2_r        <= 16'h0000;
			log_valid_r <= 1'b0;
			busy_r      <= 1'b0;
			commit_r    <= 1'b0;
		end else begin
			commit_r <= 1'b0;
			case (st_r)
				S_IDLE: begin
					// a second fault while a capture runs is folded into that capture
					if (fault_evt) begin
						st_r   <= S_PASS;
						busy_r <= 1'b1;
					end
				end
				S_PASS: begin
					if (step_vld) begin
						// temperatures are header bytes but are taken with the page
						// channel 1 temperature
						t1_r <= temp1_val;
						t2_r <= temp2_val;
						if (step_num == `FLRF_LAST_STEP) begin
							st_r   <= S_WRT;
							widx_r <= `FLRF_IDX_TEMP1_HI;
						end
					end
				end
				S_WRT: begin
					// commit header and the one event page
					// one record byte per cycle, bytes 23 through 45
					if (widx_r == `FLRF_IDX_MFR0) begin
						st_r <= S_DONE;
					end else begin
						widx_r <= widx_r + 8'h01;
					end
				end
				S_DONE: begin
					log_valid_r <= 1'b1;
					busy_r      <= 1'b0;
					commit_r    <= 1'b1;
					st_r        <= S_IDLE;
				end
				default: st_r <= S_IDLE;
			endcase
		end
	end

	// bytes outside 23..45 are never written here and read back as the memory holds them
	flrf_mem u_mem (
		.clk     (clk),
		.wr_en   (wr_en),
		.wr_addr (widx_r),
		.wr_data (wr_data),
		.rd_addr (ridx_r),
		.rd_data (mem_q)
	);

	// length latched at the start of each block read
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			blk_len_r <= `FLRF_NO_LOG_LEN;
		else if (fault_record_block_read)
			blk_len_r <= log_valid_r ? `FLRF_REC_LEN : `FLRF_NO_LOG_LEN;
	end

	// byte pointer; memory read data lag the pointer by one cycle
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ridx_r    <= 8'h00;
			rd_pend_r <= 1'b0;
		end else begin
			rd_pend_r <= take_byte;
			if (fault_record_block_read)
				ridx_r <= 8'h00;
			else if (take_byte)
				ridx_r <= ridx_r + 8'h01;
		end
	end

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_vld_r  <= 1'b0;
			rd_byte_r <= 8'h00;
		end else begin
			rd_vld_r <= rd_pend_r;
			if (rd_pend_r)
				rd_byte_r <= mem_q;
		end
	end
endmodule
